// >>> dps_host.sv
// Bus master model driving one port of the dual-port RAM
`timescale 1ns/1ps
module dps_host (
	input wire logic clk_sys,
	output dps_pkg::dps_req_t req
);
	import dps_pkg::*;
	logic pipe = 1'b0;
	dps_req_t r;
	initial req = '{16'h0, 18'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
		1'b1, 1'b1, 1'b1, 1'b0};
	// =========================================================
	// One request held a full cycle, then an idle cycle
	task automatic op(input logic rnw, input logic [15:0] a,
		input logic [17:0] d, input logic [1:0] ln = 2'b00,
		input logic [2:0] ctl = 3'b011, input logic [1:0] sel = 2'b01);
		@(posedge clk_sys);
		r = '{a, d, rnw, sel[1], sel[0], ln[1], ln[0], ctl[2], ctl[1],
			ctl[0], pipe};
		req <= r;
		@(posedge clk_sys);
		// Inverted leftovers so stale pins never look valid
		r.addr = ~a;
		r.wdata = ~d;
		r.primary_select_n = 1'b1;
		{r.address_load_n, r.counter_step_n, r.counter_clear_n} = 3'b111;
		req <= r;
	endtask
endmodule

// >>> dps_map.svh
// Address, width and field constants of the dual-port synchronous RAM port
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH
`define DPS_ADDR_W 16
`define DPS_DATA_W 18
`define DPS_DEPTH 65536
`define DPS_NUM_PORTS 2
`define DPS_LANE_UP 1
`define DPS_LANE_LO 0
`define DPS_ADDR_RST 16'h0000
`define DPS_DATA_RST 18'h0_0000
`endif

// >>> dps_pkg.sv
// Types shared by the dual-port synchronous RAM port logic
`include "dps_map.svh"
package dps_pkg;
	// One port's pins as sampled at a clock edge
	typedef struct packed {
		logic [`DPS_ADDR_W-1:0] addr;
		logic [`DPS_DATA_W-1:0] wdata;
		logic read_not_write;
		logic primary_select_n;
		logic secondary_select;
		logic upper_lane_select_n;
		logic lower_lane_select_n;
		logic address_load_n;
		logic counter_step_n;
		logic counter_clear_n;
		logic output_latency_select;
	} dps_req_t;
	// Per-lane output enables, bit 1 upper, bit 0 lower
	typedef logic [1:0] dps_lanes_t;
endpackage

// >>> dps_ram.sv
// Dual-port synchronous RAM with address counters and selectable latency
// Function
// - Shared 64K-word array, both ports access any address concurrently.
// - Each port registers address, data and controls on its clock edge.
// - Latency pin per port picks flow-through or pipelined read output.
// - Either chip enable inactive deselects port: lanes float, standby.
// - Data split into upper and lower lanes, each with its own select.
// - Enabled write stores only lanes whose select is low.
// - Enabled read with output drive low drives only selected lanes.
// - Output drive high floats both lanes asynchronously.
// - Lane selects pass one register stage in either latency mode.
// - Chip enables pass one stage flow-through, two stages pipelined.
// - Counter clear low loads address zero regardless of other inputs.
// - Address load low loads external address into counter.
// - Counter step low increments address; otherwise address is reused.
// - Pipelined read data arrives one cycle after flow-through data.
`timescale 1ns/1ps
`include "dps_map.svh"
module dps_ram #(
	parameter int ADDR_W = `DPS_ADDR_W,
	parameter int DATA_W = `DPS_DATA_W,
	parameter int DEPTH = `DPS_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic ce,
	input dps_pkg::dps_req_t req [`DPS_NUM_PORTS],
	input wire logic [`DPS_NUM_PORTS-1:0] output_drive_n,
	output logic [DATA_W-1:0] dq_o [`DPS_NUM_PORTS],
	output dps_pkg::dps_lanes_t dq_oe [`DPS_NUM_PORTS],
	output logic [`DPS_NUM_PORTS-1:0] standby
);
	import dps_pkg::*;

	localparam int NP = `DPS_NUM_PORTS;
	localparam int LW = DATA_W / 2;

	// ==========================================================
	// Storage and per-port state
	logic [DATA_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] addr_q [NP];
	logic [ADDR_W-1:0] next_addr [NP];
	logic [DATA_W-1:0] rd_word [NP];
	logic [DATA_W-1:0] rd_q [NP];
	logic [NP-1:0] next_en;
	logic [NP-1:0] rd_now;
	logic [NP-1:0] rd1;
	dps_lanes_t oe_q [NP];

	// ==========================================================
	// Address counter and access decode
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			if (!req[p].counter_clear_n) begin
				next_addr[p] = `DPS_ADDR_RST;
			end else if (!req[p].address_load_n) begin
				next_addr[p] = req[p].addr;
			end else if (!req[p].counter_step_n) begin
				next_addr[p] = addr_q[p] + 1'b1;
			end else begin
				next_addr[p] = addr_q[p];
			end
			// Both enables must agree or the port stays deselected
			next_en[p] = !req[p].primary_select_n &&
				req[p].secondary_select;
			rd_now[p] = next_en[p] && req[p].read_not_write;
			rd_word[p] = mem[next_addr[p]];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NP; p++) begin
				addr_q[p] <= `DPS_ADDR_RST;
			end
		end else if (ce) begin
			for (int p = 0; p < NP; p++) begin
				addr_q[p] <= next_addr[p];
			end
		end
	end

	// ==========================================================
	// Array writes
	// Same-address writes from both ports: the higher port wins the lane.
	// Reads in the write cycle return the old word.
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			for (int p = 0; p < NP; p++) begin
				if (next_en[p] && !req[p].read_not_write) begin
					if (!req[p].upper_lane_select_n) begin
						mem[next_addr[p]][DATA_W-1:LW] <=
							req[p].wdata[DATA_W-1:LW];
					end
					if (!req[p].lower_lane_select_n) begin
						mem[next_addr[p]][LW-1:0] <=
							req[p].wdata[LW-1:0];
					end
				end
			end
		end
	end

	// ==========================================================
	// Read data and lane enables
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			for (int p = 0; p < NP; p++) begin
				rd_q[p] <= `DPS_DATA_RST;
				dq_o[p] <= `DPS_DATA_RST;
			end
		end else if (ce) begin
			for (int p = 0; p < NP; p++) begin
				rd_q[p] <= rd_word[p];
				// Pipelined output takes the word one edge later
				dq_o[p] <= req[p].output_latency_select ?
					rd_q[p] : rd_word[p];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rd1 <= '0;
			standby <= '1;
			for (int p = 0; p < NP; p++) begin
				oe_q[p] <= 2'b00;
			end
		end else if (ce) begin
			rd1 <= rd_now;
			for (int p = 0; p < NP; p++) begin
				standby[p] <= req[p].output_latency_select ?
					!rd1[p] && !next_en[p] : !next_en[p];
				// Enables see one extra stage when pipelined
				oe_q[p][`DPS_LANE_UP] <= (req[p].output_latency_select ?
					rd1[p] : rd_now[p]) &&
					!req[p].upper_lane_select_n;
				oe_q[p][`DPS_LANE_LO] <= (req[p].output_latency_select ?
					rd1[p] : rd_now[p]) &&
					!req[p].lower_lane_select_n;
			end
		end
	end

	// Output drive is asynchronous, so it gates the registered enables
	always_comb begin
		for (int p = 0; p < NP; p++) begin
			dq_oe[p] = output_drive_n[p] ? 2'b00 : oe_q[p];
		end
	end

	// ==========================================================
	// Checks on port 0, with freeze and port 1 spot checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	logic w1_same;
	assign w1_same = next_en[1] && !req[1].read_not_write &&
		next_addr[1] == next_addr[0];

	sequence s_read_ft;
		ce && rd_now[0] && !req[0].output_latency_select;
	endsequence
	sequence s_read_pipe;
		ce && rd_now[0] && req[0].output_latency_select ##1
			ce && req[0].output_latency_select;
	endsequence
	sequence s_idle_pipe;
		ce && !next_en[0] && req[0].output_latency_select;
	endsequence

	property p_clear;
		ce && !req[0].counter_clear_n |=> addr_q[0] == `DPS_ADDR_RST;
	endproperty
	a_clear: assert property (p_clear)
		else $error("counter clear did not zero address");

	property p_load;
		ce && req[0].counter_clear_n && !req[0].address_load_n
			|=> addr_q[0] == $past(req[0].addr);
	endproperty
	a_load: assert property (p_load)
		else $error("address load not taken");

	property p_step;
		ce && req[0].counter_clear_n && req[0].address_load_n
			|=> addr_q[0] == ADDR_W'($past(addr_q[0]) +
			{{(ADDR_W-1){1'b0}}, !$past(req[0].counter_step_n)});
	endproperty
	a_step: assert property (p_step)
		else $error("counter step or hold wrong");

	property p_ft_data;
		s_read_ft |=> dq_o[0] == $past(rd_word[0]);
	endproperty
	a_ft_data: assert property (p_ft_data)
		else $error("flow-through read data wrong");

	property p_pipe_data;
		s_read_pipe |=> dq_o[0] == $past(rd_word[0], 2);
	endproperty
	a_pipe_data: assert property (p_pipe_data)
		else $error("pipelined read data not one cycle later");

	property p_async_off;
		output_drive_n[0] |-> dq_oe[0] == 2'b00;
	endproperty
	a_async_off: assert property (p_async_off)
		else $error("lanes driven with output drive high");

	property p_desel_ft;
		ce && !next_en[0] && !req[0].output_latency_select
			|=> oe_q[0] == 2'b00 && standby[0];
	endproperty
	a_desel_ft: assert property (p_desel_ft)
		else $error("flow-through deselect not immediate");

	property p_desel_pipe;
		ce && !next_en[0] && req[0].output_latency_select ##1
			ce && !next_en[0] && req[0].output_latency_select
			|=> oe_q[0] == 2'b00;
	endproperty
	a_desel_pipe: assert property (p_desel_pipe)
		else $error("pipelined deselect not after two cycles");

	property p_lanes;
		s_read_ft |=> oe_q[0] == {!$past(req[0].upper_lane_select_n),
			!$past(req[0].lower_lane_select_n)};
	endproperty
	a_lanes: assert property (p_lanes)
		else $error("lane enables do not follow lane selects");

	property p_write_lo;
		ce && next_en[0] && !req[0].read_not_write &&
			!req[0].lower_lane_select_n && !w1_same
			|=> mem[$past(next_addr[0])][LW-1:0] ==
			$past(req[0].wdata[LW-1:0]);
	endproperty
	a_write_lo: assert property (p_write_lo)
		else $error("lower lane write not stored");

	property p_write_up;
		ce && next_en[0] && !req[0].read_not_write &&
			!req[0].upper_lane_select_n && !w1_same
			|=> mem[$past(next_addr[0])][DATA_W-1:LW] ==
			$past(req[0].wdata[DATA_W-1:LW]);
	endproperty
	a_write_up: assert property (p_write_up)
		else $error("upper lane write not stored");

	// Standby must be reached after two idle edges when pipelined
	property p_standby_pipe;
		s_idle_pipe ##1 s_idle_pipe |=> standby[0];
	endproperty
	a_standby_pipe: assert property (p_standby_pipe)
		else $error("pipelined standby not reached");

	property p_async_on;
		!output_drive_n[0] |-> dq_oe[0] == oe_q[0];
	endproperty
	a_async_on: assert property (p_async_on)
		else $error("lanes not driven with output drive low");

	// Data word left out: unwritten words may read as unknown
	property p_freeze;
		!ce |=> addr_q[0] == $past(addr_q[0]) &&
			addr_q[1] == $past(addr_q[1]) &&
			oe_q[0] == $past(oe_q[0]) && standby == $past(standby);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("state moved with clock enable low");

	// ==========================================================
	// Port 1 spot checks
	property p_ft_data_p1;
		ce && rd_now[1] && !req[1].output_latency_select
			|=> dq_o[1] == $past(rd_word[1]);
	endproperty
	a_ft_data_p1: assert property (p_ft_data_p1)
		else $error("port 1 read data wrong");

	property p_lanes_p1;
		ce && rd_now[1] && !req[1].output_latency_select
			|=> oe_q[1] == {!$past(req[1].upper_lane_select_n),
			!$past(req[1].lower_lane_select_n)};
	endproperty
	a_lanes_p1: assert property (p_lanes_p1)
		else $error("port 1 lane enables wrong");

	property p_async_off_p1;
		output_drive_n[1] |-> dq_oe[1] == 2'b00;
	endproperty
	a_async_off_p1: assert property (p_async_off_p1)
		else $error("port 1 lanes driven with output drive high");

	property p_clear_p1;
		ce && !req[1].counter_clear_n |=> addr_q[1] == `DPS_ADDR_RST;
	endproperty
	a_clear_p1: assert property (p_clear_p1)
		else $error("port 1 counter clear did not zero address");

	property p_load_p1;
		ce && req[1].counter_clear_n && !req[1].address_load_n
			|=> addr_q[1] == $past(req[1].addr);
	endproperty
	a_load_p1: assert property (p_load_p1)
		else $error("port 1 address load not taken");
endmodule

// >>> tb.sv
// Self-checking bench for the dual-port RAM port logic
`timescale 1ns/1ps
`include "dps_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	mismatches++; $display("FAIL %0t got %0h", $time, (a)); end end
module tb;
	import dps_pkg::*;
	localparam logic [17:0] d0 = 18'h2_a5c3;
	localparam logic [17:0] d1 = 18'h1_5a5a;
	localparam logic [15:0] a0 = 16'h1234;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	dps_req_t req [`DPS_NUM_PORTS];
	logic [1:0] output_drive_n = 2'b00;
	logic [17:0] dq_o [`DPS_NUM_PORTS];
	dps_lanes_t dq_oe [`DPS_NUM_PORTS];
	logic [1:0] standby;
	int mismatches = 0;
	int check_count = 0;
	always #5 clk_sys = ~clk_sys;
	dps_host m0 (.clk_sys(clk_sys), .req(req[0]));
	dps_host m1 (.clk_sys(clk_sys), .req(req[1]));
	dps_ram dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .req(req),
		.output_drive_n(output_drive_n), .dq_o(dq_o), .dq_oe(dq_oe),
		.standby(standby));
	task automatic results();
		$display("Checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// =========================================================
	// Scenarios
	task automatic t_rw();
		m0.op(1'b0, a0, d0);
		fork
			m0.op(1'b1, a0, 18'h0);
			m1.op(1'b1, a0, 18'h0);
		join
		#1;
		`CHK(dq_o[0], d0)
		`CHK(dq_o[1], d0)
		`CHK(dq_oe[0], 2'b11)
		`CHK(dq_oe[1], 2'b11)
		`CHK(standby, 2'b00)
	endtask
	task automatic t_lanes();
		m0.op(1'b0, a0, d1, 2'b10);
		m0.op(1'b1, a0, 18'h0);
		#1;
		`CHK(dq_o[0], {d0[17:9], d1[8:0]})
		m0.op(1'b1, a0, 18'h0, 2'b01);
		#1;
		`CHK(dq_oe[0], 2'b10)
		m0.op(1'b1, a0, 18'h0, 2'b11);
		#1;
		`CHK(dq_oe[0], 2'b00)
	endtask
	task automatic t_off();
		@(posedge clk_sys);
		output_drive_n <= 2'b01;
		m0.op(1'b1, a0, 18'h0);
		#1;
		`CHK(dq_oe[0], 2'b00)
		`CHK(dq_o[0], {d0[17:9], d1[8:0]})
		@(posedge clk_sys);
		output_drive_n <= 2'b00;
		m0.op(1'b1, a0, 18'h0, 2'b00, 3'b011, 2'b11);
		#1;
		`CHK(standby[0], 1'b1)
		m0.op(1'b1, a0, 18'h0, 2'b00, 3'b011, 2'b00);
		#1;
		`CHK(dq_oe[0], 2'b00)
	endtask
	task automatic t_cnt();
		m0.op(1'b0, a0, d0, 2'b00, 3'b110);
		m0.op(1'b0, a0, d1, 2'b00, 3'b101);
		m0.op(1'b1, a0, 18'h0, 2'b00, 3'b111);
		#1;
		`CHK(dq_o[0], d1)
		m0.op(1'b1, a0, 18'h0, 2'b00, 3'b110, 2'b11);
		m0.op(1'b1, a0, 18'h0, 2'b00, 3'b111);
		#1;
		`CHK(dq_o[0], d0)
	endtask
	// Clock enable low must drop the whole write and hold the outputs
	task automatic t_freeze();
		@(posedge clk_sys);
		ce <= 1'b0;
		m0.op(1'b0, a0, d1);
		ce <= 1'b1;
		#1;
		`CHK(dq_o[0], d0)
		m0.op(1'b1, a0, 18'h0);
		#1;
		`CHK(dq_o[0], {d0[17:9], d1[8:0]})
	endtask
	task automatic t_pipe();
		m0.pipe = 1'b1;
		m0.op(1'b1, a0, 18'h0, 2'b00, 3'b011, 2'b11);
		m0.op(1'b1, a0, 18'h0);
		#1;
		`CHK(dq_oe[0], 2'b00)
		@(posedge clk_sys);
		#1;
		`CHK(dq_o[0], {d0[17:9], d1[8:0]})
		`CHK(dq_oe[0], 2'b11)
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		`CHK(standby, 2'b11)
		rst_b <= 1'b1;
		t_rw();
		t_lanes();
		t_off();
		t_cnt();
		t_freeze();
		t_pipe();
		results();
	end
	initial begin
		#100000;
		mismatches++;
		results();
	end
endmodule
